// File: design/zacs_regs.vh
// Register map, field positions, reset values and timing counts of the
// zoom converter sequencer. Included by every design file.
// Assumes a 16-bit register port with 4-bit word addresses.
`ifndef ZACS_REGS_VH
`define ZACS_REGS_VH

// ****************************************************************
// Register offsets (word addresses)
// ****************************************************************
`define ZACS_ADDR_W 4
`define ZACS_DATA_W 16
`define ZACS_OFF_CFG0 4'h0
`define ZACS_OFF_CTRL 4'h1
`define ZACS_OFF_STAGE2 4'h2
`define ZACS_OFF_S3GAIN 4'h3
`define ZACS_OFF_S3OFFS 4'h4
`define ZACS_OFF_STATUS 4'h5
`define ZACS_OFF_RESULT 4'h6
`define ZACS_OFF_IRQSTAT 4'h7
`define ZACS_OFF_IRQEN 4'h8
`define ZACS_OFF_IRQCLR 4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define ZACS_CFG0_START 0
`define ZACS_CFG0_DEF 1
`define ZACS_CFG0_OSR_LO 2
`define ZACS_CFG0_NELC_LO 5
`define ZACS_CTRL_EN_LO 0
`define ZACS_CTRL_S1GAIN 4
`define ZACS_CTRL_RATE_LO 5
`define ZACS_S2_GAIN_LO 0
`define ZACS_S2_OFFS_LO 2
`define ZACS_STAT_BUSY 0
`define ZACS_STAT_RES_LO 4
`define ZACS_IRQ_DONE 0
`define ZACS_IRQ_REFUSED 1

// ****************************************************************
// Reset values
// ****************************************************************
`define ZACS_RST_CFG0 7'h00
`define ZACS_RST_CTRL 7'h00
`define ZACS_RST_RESULT 16'h0000

// ****************************************************************
// Timing and arithmetic constants
// ****************************************************************
`define ZACS_DIV_C0 16'h0004
`define ZACS_DIV_C1 16'h0008
`define ZACS_DIV_C2 16'h0020
`define ZACS_SLOW_DIV 31250
`define ZACS_INIT_CYC 3'h3
`define ZACS_TERM_CYC 3'h3
`define ZACS_OSR_BASE 3
`define ZACS_RES_BASE 5'h06
`define ZACS_RES_MAX 5'h10

`endif

// File: design/zacs_rate_div.v
// Sampling-rate divider: turns the converter clock into a one-cycle
// sample enable. Assumes the select word is stable while it runs.
`timescale 1ns/1ps
`include "zacs_regs.vh"

module zacs_rate_div #(
  parameter slowDiv = `ZACS_SLOW_DIV
) (
  input wire clock,
  input wire nrst,
  input wire run,
  input wire [1:0] rateSel,
  output reg tick
);

  reg [15:0] count_reg;
  reg [15:0] last;

  // Code 11 is a slow rate, the same clock divided by slowDiv
  always @* begin
    case (rateSel)
      2'h0: last = `ZACS_DIV_C0 - 16'h0001;
      2'h1: last = `ZACS_DIV_C1 - 16'h0001;
      2'h2: last = `ZACS_DIV_C2 - 16'h0001;
      default: last = slowDiv[15:0] - 16'h0001;
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      count_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (count_reg >= last) begin
      count_reg <= 16'h0000;
      tick <= 1'b1; // [RULE7]
    end else begin
      count_reg <= count_reg + 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule

// File: design/zacs_accum.v
// Running sum of modulator decisions over a whole conversion.
// Assumes one modulator bit per sample enable.
`timescale 1ns/1ps
`include "zacs_regs.vh"

module zacs_accum (
  input wire clock,
  input wire nrst,
  input wire clear,
  input wire sampleEn,
  input wire modBit,
  input wire polarity,
  output reg signed [15:0] sum
);

  // Flipping the sign on odd elementary conversions makes the front-end
  // offset, which is also inverted there, cancel in the sum
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sum <= 16'sh0000;
    end else if (clear) begin
      sum <= 16'sh0000;
    end else if (sampleEn) begin
      if (modBit ^ polarity) begin
        sum <= sum + 16'sh0001; // [RULE5]
      end else begin
        sum <= sum - 16'sh0001; // [RULE5]
      end
    end
  end

endmodule

// File: design/zacs_top.v
// Conversion sequencer and control registers of the zoom converter.
// Assumes the clock is the RC-derived converter clock and the analog
// chain samples modBit on each sampleTick it receives.
//
// Contract
// (RULE1) A conversion starts when software writes start or default-start.
// (RULE2) Programmed elementary conversions, then one final quantization step.
// (RULE3) Each elementary conversion lasts oversampling ratio plus one samples.
// (RULE4) Result is the mean of all elementary conversion results.
// (RULE5) Elementary conversions alternate offset polarity so offset cancels.
// (RULE6) Few extra clock cycles before first and after last conversion.
// (RULE7) Rate select: clock over 4, 8, 32, or a slow fixed rate.
// (RULE8) Oversampling code in config 0 bits 4:2 gives ratio 2^(3+code).
// (RULE9) Elementary count code in config 0 bits 6:5 gives 2^code.
// (RULE10) Software should program at least two elementary conversions.
// (RULE11) Resolution is 2*oversample code plus count code plus 6, max 16.
// (RULE12) Stage enables gate each gain stage; converter may be disabled.
// (RULE13) First stage gain bit: unity or gain of ten.
// (RULE14) Second stage takes two-bit gain and four-bit offset codes.
// (RULE15) Third stage takes seven-bit gain and offset codes, feeds converter.
// (RULE16) Enable word: bit0 converter, bits 1 to 3 the three stages.
// (RULE17) Busy rises at effective start, up to one sample period late.
// (RULE18) After final quantization, load 16-bit result and clear busy.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "zacs_regs.vh"

module zacs_top #(
  parameter slowDiv = `ZACS_SLOW_DIV
) (
  input wire clock,
  input wire nrst,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  output reg irq,
  input wire modBit,
  output reg adcEnable,
  output reg stage1Enable,
  output reg stage2Enable,
  output reg stage3Enable,
  output reg stage1_gain_sel,
  output reg [1:0] stage2_gain_sel,
  output reg [3:0] stage2_offset_sel,
  output reg [6:0] stage3_gain_sel,
  output reg [6:0] stage3_offset_sel,
  output reg sampleTick,
  output reg chopPolarity,
  output reg integReset,
  output reg quantStrobe,
  output reg busy
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [4:0] resolution;
    input [2:0] osr;
    input [1:0] nelc;
    reg [4:0] raw;
    begin
      raw = {1'b0, osr, 1'b0} + {3'h0, nelc} + `ZACS_RES_BASE;
      resolution = (raw > `ZACS_RES_MAX) ? `ZACS_RES_MAX : raw; // [RULE11]
    end
  endfunction

  function [10:0] osrValue;
    input [2:0] osr;
    begin
      osrValue = 11'h001 << (osr + `ZACS_OSR_BASE); // [RULE8]
    end
  endfunction

  localparam [2:0] stIdle = 3'h0;
  localparam [2:0] stInit = 3'h1;
  localparam [2:0] stElem = 3'h2;
  localparam [2:0] stQuant = 3'h3;
  localparam [2:0] stTerm = 3'h4;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg defStart_reg;
  reg [2:0] osrSel_reg;
  reg [1:0] nelcSel_reg;
  reg [1:0] rateSel_reg;
  reg [15:0] result_reg;
  reg [1:0] irqStat_reg;
  reg [1:0] irqEn_reg;
  reg startPend_reg;
  reg [2:0] state_reg;
  reg [2:0] cycCnt_reg;
  reg [10:0] sampCnt_reg;
  reg [3:0] elemCnt_reg;
  reg [2:0] runOsr_reg;
  reg [1:0] runNelc_reg;
  reg doneEvt;
  reg refusedEvt;

  wire rateTick;
  wire signed [15:0] sum;
  wire wrCfg0 = regWrite && (regAddr == `ZACS_OFF_CFG0);
  wire startReq = wrCfg0 && (regWdata[`ZACS_CFG0_START] ||
                  regWdata[`ZACS_CFG0_DEF]);
  wire sampleEn = rateTick && (state_reg == stElem);
  wire [10:0] lastSamp = osrValue(runOsr_reg);
  wire [3:0] lastElem = (4'h1 << runNelc_reg) - 4'h1;
  wire [4:0] curRes = resolution(runOsr_reg, runNelc_reg);

  // Full scale of one elementary conversion is 2^(3+osr); shift it to
  // 2^15, then divide by the count. 32 bits keep the product exact.
  // Signed on purpose: the divide by the count must shift in the sign
  wire signed [31:0] sumWide = {{16{sum[15]}}, sum};
  wire signed [31:0] scaled = (sumWide <<<
                               (5'd12 - {2'h0, runOsr_reg})) >>>
                              runNelc_reg; // [RULE4]
  wire [15:0] satVal = (scaled > 32'sd32767) ? 16'h7fff :
                       (scaled < -32'sd32768) ? 16'h8000 :
                       scaled[15:0];
  // Bits below the resolution carry no information and are cleared
  wire [15:0] resMask = 16'hffff << (`ZACS_RES_MAX - curRes); // [RULE11]

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  zacs_rate_div #(
    .slowDiv(slowDiv)
  ) uRateDiv (
    .clock(clock),
    .nrst(nrst),
    .run(adcEnable),
    .rateSel(rateSel_reg),
    .tick(rateTick)
  );

  zacs_accum uAccum (
    .clock(clock),
    .nrst(nrst),
    .clear(state_reg == stInit),
    .sampleEn(sampleEn),
    .modBit(modBit),
    .polarity(chopPolarity),
    .sum(sum)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      defStart_reg <= 1'b0;
      osrSel_reg <= 3'h0;
      nelcSel_reg <= 2'h0;
      rateSel_reg <= 2'h0;
      adcEnable <= 1'b0;
      stage1Enable <= 1'b0;
      stage2Enable <= 1'b0;
      stage3Enable <= 1'b0;
      stage1_gain_sel <= 1'b0;
      stage2_gain_sel <= 2'h0;
      stage2_offset_sel <= 4'h0;
      stage3_gain_sel <= 7'h00;
      stage3_offset_sel <= 7'h00;
      irqEn_reg <= 2'h0;
    end else if (regWrite) begin
      case (regAddr)
        `ZACS_OFF_CFG0: begin
          defStart_reg <= regWdata[`ZACS_CFG0_DEF];
          osrSel_reg <= regWdata[`ZACS_CFG0_OSR_LO +: 3]; // [RULE8]
          nelcSel_reg <= regWdata[`ZACS_CFG0_NELC_LO +: 2]; // [RULE9]
        end
        `ZACS_OFF_CTRL: begin
          adcEnable <= regWdata[`ZACS_CTRL_EN_LO]; // [RULE12] [RULE16]
          stage1Enable <= regWdata[`ZACS_CTRL_EN_LO + 1]; // [RULE16]
          stage2Enable <= regWdata[`ZACS_CTRL_EN_LO + 2]; // [RULE16]
          stage3Enable <= regWdata[`ZACS_CTRL_EN_LO + 3]; // [RULE16]
          stage1_gain_sel <= regWdata[`ZACS_CTRL_S1GAIN]; // [RULE13]
          rateSel_reg <= regWdata[`ZACS_CTRL_RATE_LO +: 2]; // [RULE7]
        end
        `ZACS_OFF_STAGE2: begin
          stage2_gain_sel <= regWdata[`ZACS_S2_GAIN_LO +: 2]; // [RULE14]
          stage2_offset_sel <= regWdata[`ZACS_S2_OFFS_LO +: 4]; // [RULE14]
        end
        `ZACS_OFF_S3GAIN: stage3_gain_sel <= regWdata[6:0]; // [RULE15]
        `ZACS_OFF_S3OFFS: stage3_offset_sel <= regWdata[6:0]; // [RULE15]
        `ZACS_OFF_IRQEN: irqEn_reg <= regWdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      startPend_reg <= 1'b0;
      state_reg <= stIdle;
      cycCnt_reg <= 3'h0;
      sampCnt_reg <= 11'h000;
      elemCnt_reg <= 4'h0;
      runOsr_reg <= 3'h0;
      runNelc_reg <= 2'h0;
      result_reg <= `ZACS_RST_RESULT;
      busy <= 1'b0;
      chopPolarity <= 1'b0;
      integReset <= 1'b0;
      quantStrobe <= 1'b0;
      sampleTick <= 1'b0;
      doneEvt <= 1'b0;
      refusedEvt <= 1'b0;
    end else begin
      sampleTick <= sampleEn || (rateTick && state_reg == stQuant);
      quantStrobe <= 1'b0;
      doneEvt <= 1'b0;
      refusedEvt <= 1'b0;
      // Starting while busy or disabled is dropped and flagged
      if (startReq && (busy || startPend_reg || !adcEnable)) begin
        refusedEvt <= 1'b1;
      end else if (startReq) begin
        startPend_reg <= 1'b1; // [RULE1]
      end
      if (!adcEnable) begin
        state_reg <= stIdle;
        busy <= 1'b0;
        startPend_reg <= 1'b0;
        integReset <= 1'b0;
      end else begin
        case (state_reg)
          stIdle: begin
            // Aligning the start to the sample rate delays busy by up
            // to one sample period after the write
            if (startPend_reg && rateTick) begin
              startPend_reg <= 1'b0;
              busy <= 1'b1; // [RULE17]
              runOsr_reg <= osrSel_reg;
              runNelc_reg <= nelcSel_reg;
              chopPolarity <= 1'b0;
              integReset <= 1'b1;
              cycCnt_reg <= 3'h0;
              state_reg <= stInit;
            end
          end
          stInit: begin
            if (cycCnt_reg == `ZACS_INIT_CYC - 3'h1) begin
              integReset <= 1'b0; // [RULE6]
              sampCnt_reg <= 11'h000;
              elemCnt_reg <= 4'h0;
              state_reg <= stElem;
            end else begin
              cycCnt_reg <= cycCnt_reg + 3'h1; // [RULE6]
            end
          end
          stElem: begin
            if (rateTick) begin
              if (sampCnt_reg == lastSamp) begin
                sampCnt_reg <= 11'h000; // [RULE3]
                chopPolarity <= ~chopPolarity; // [RULE5]
                if (elemCnt_reg == lastElem) begin
                  state_reg <= stQuant; // [RULE2]
                end else begin
                  elemCnt_reg <= elemCnt_reg + 4'h1; // [RULE2]
                  integReset <= 1'b1;
                end
              end else begin
                sampCnt_reg <= sampCnt_reg + 11'h001; // [RULE3]
                integReset <= 1'b0;
              end
            end
          end
          stQuant: begin
            if (rateTick) begin
              quantStrobe <= 1'b1; // [RULE2]
              cycCnt_reg <= 3'h0;
              state_reg <= stTerm;
            end
          end
          stTerm: begin
            if (cycCnt_reg == `ZACS_TERM_CYC - 3'h1) begin
              result_reg <= satVal & resMask; // [RULE18]
              busy <= 1'b0; // [RULE18]
              doneEvt <= 1'b1;
              state_reg <= stIdle;
            end else begin
              cycCnt_reg <= cycCnt_reg + 3'h1; // [RULE6]
            end
          end
          default: state_reg <= stIdle;
        endcase
      end
    end
  end

  // ****************************************************************
  // Interrupts and read port
  // ****************************************************************
  wire irqClr = regWrite && (regAddr == `ZACS_OFF_IRQCLR);
  wire [1:0] clrMask = irqClr ? regWdata[1:0] : 2'h0;
  wire [1:0] events = {refusedEvt, doneEvt};
  wire [1:0] irqStat_next = (irqStat_reg & ~clrMask) | events;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= 2'h0;
      irq <= 1'b0;
      regRdata <= 16'h0000;
    end else begin
      // A new event in the clearing cycle survives the clear
      irqStat_reg <= irqStat_next;
      irq <= |(irqStat_next & irqEn_reg);
      regRdata <= 16'h0000;
      if (regRead) begin
        case (regAddr)
          `ZACS_OFF_CFG0: regRdata <= {9'h000, nelcSel_reg, osrSel_reg,
                                       defStart_reg, 1'b0};
          `ZACS_OFF_CTRL: regRdata <= {9'h000, rateSel_reg,
                                       stage1_gain_sel, stage3Enable,
                                       stage2Enable, stage1Enable,
                                       adcEnable};
          `ZACS_OFF_STAGE2: regRdata <= {10'h000, stage2_offset_sel,
                                         stage2_gain_sel};
          `ZACS_OFF_S3GAIN: regRdata <= {9'h000, stage3_gain_sel};
          `ZACS_OFF_S3OFFS: regRdata <= {9'h000, stage3_offset_sel};
          `ZACS_OFF_STATUS: regRdata <= {7'h00,
                                         resolution(osrSel_reg,
                                                    nelcSel_reg),
                                         3'h0, busy}; // [RULE11]
          `ZACS_OFF_RESULT: regRdata <= result_reg;
          `ZACS_OFF_IRQSTAT: regRdata <= {14'h0000, irqStat_reg};
          `ZACS_OFF_IRQEN: regRdata <= {14'h0000, irqEn_reg};
          default: regRdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// File: verification/zacs_top_properties.sv
// Port checker of the sequencer top, bound to every zacs_top instance.
// Assumes rate code 11 divides by slowDiv, kept small in simulation.
`timescale 1ns/1ps
// ****
// Checker
// ****
module zacs_top_properties #(
  parameter int slowDiv = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic irq,
  input wire logic adcEnable,
  input wire logic stage1Enable,
  input wire logic stage2Enable,
  input wire logic stage3Enable,
  input wire logic sampleTick,
  input wire logic integReset,
  input wire logic quantStrobe,
  input wire logic busy
);
  // Worst start lag: one full sample period plus register stages
  localparam int startMax = (slowDiv > 32 ? slowDiv : 32) + 4;
  logic [1:0] rate_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  always @(posedge clock or negedge nrst) begin
    if (!nrst) rate_reg <= 2'h0;
    else if (regWrite && regAddr == 4'h1) rate_reg <= regWdata[6:5];
  end
  AST_TICK_ONE: assert property (sampleTick |=> !sampleTick)
    else $error("sample tick longer than one cycle");
  AST_RATE4: assert property (sampleTick && rate_reg == 2'h0
    |=> !sampleTick [*3]) else $error("ticks closer than 4 clocks");
  AST_RATE8: assert property (sampleTick && rate_reg == 2'h1
    |=> !sampleTick [*7]) else $error("ticks closer than 8 clocks");
  AST_QUANT_ONE: assert property (
    quantStrobe |-> busy ##1 !quantStrobe)
    else $error("quantization strobe outside a conversion");
  AST_QUANT_END: assert property (quantStrobe |-> ##[2:8] !busy)
    else $error("busy stayed after quantization");
  AST_BUSY_EN: assert property (
    !adcEnable && !$past(adcEnable) |-> !busy)
    else $error("busy while converter disabled");
  AST_START: assert property (regWrite && regAddr == 4'h0
    && (|regWdata[1:0]) && adcEnable && !busy |-> ##[1:startMax] busy)
    else $error("start did not raise busy");
  AST_RDATA_ZERO: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
  AST_CTRL: assert property (regWrite && regAddr == 4'h1 |=>
    {stage3Enable, stage2Enable, stage1Enable, adcEnable}
    == $past(regWdata[3:0])) else $error("enable outputs wrong");
  AST_INIT: assert property ($rose(busy) |-> ##[0:1] integReset)
    else $error("no initial integrator reset");
  cover property ($fell(busy) && adcEnable);
  cover property (quantStrobe);
  cover property ($rose(irq));
  cover property ($fell(busy) && !adcEnable);
endmodule
bind zacs_top zacs_top_properties #(.slowDiv(slowDiv)) uProps (.clock,
  .nrst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq,
  .adcEnable, .stage1Enable, .stage2Enable, .stage3Enable, .sampleTick,
  .integReset, .quantStrobe, .busy);

// File: verification/zacs_front_model.sv
// Model of the gain chain and modulator in front of the sequencer.
// Assumes the bench picks one modulator level for each conversion.
`timescale 1ns/1ps
// ****
// Front end
// ****
module zacs_front_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic adcEnable,
  input wire logic level,
  output logic modBit
);
  // A powered-down chain gives no steady level, so it toggles
  always @(posedge clock or negedge nrst) begin
    if (!nrst) modBit <= 1'b0;
    else if (adcEnable) modBit <= level;
    else modBit <= ~modBit;
  end
endmodule

// File: verification/zacs_test.sv
// Self-checking bench of the sequencer top with the front-end model.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
// ****
// Bench
// ****
module zoom_adc_conversion_sequencer_test;
  logic clock = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic level = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, v;
  logic [31:0] seed = 32'heab2_9274, r;
  wire [15:0] regRdata;
  wire [1:0] stage2_gain_sel;
  wire [3:0] stage2_offset_sel;
  wire [6:0] stage3_gain_sel, stage3_offset_sel;
  wire irq, modBit, adcEnable, stage1Enable, stage2Enable, stage3Enable;
  wire stage1_gain_sel, sampleTick, chopPolarity, integReset, quantStrobe;
  wire busy;
  int bad_count = 0, check_count = 0;
  int divTab[4] = '{4, 8, 32, 16};
  // rate | osr << 2 | count << 5 | level << 7 | default start << 8
  int cases[$] = '{32'h080, 32'h1A1, 32'h002, 32'h187, 32'h048, 32'h0E0};
  always #2 clock = ~clock;
  zacs_top #(.slowDiv(16)) dut (.clock, .nrst, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .irq, .modBit, .adcEnable,
    .stage1Enable, .stage2Enable, .stage3Enable, .stage1_gain_sel,
    .stage2_gain_sel, .stage2_offset_sel, .stage3_gain_sel,
    .stage3_offset_sel, .sampleTick, .chopPolarity, .integReset,
    .quantStrobe, .busy);
  zacs_front_model front (.clock, .nrst, .adcEnable, .level, .modBit);
  function automatic logic [31:0] nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expResult(int osr, int nelc, int lvl);
    int s = 0;
    int res = 2 * osr + nelc + 6;
    for (int e = 0; e < (1 << nelc); e++)
      s += (((e % 2) == 0) == (lvl == 1) ? 1 : -1) * ((8 << osr) + 1);
    s = (s <<< (12 - osr)) >>> nelc;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    if (res > 16) res = 16;
    return 16'(s) & ~16'((1 << (16 - res)) - 1);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic waitBusy(input logic want);
    int n = 0;
    while (busy !== want && n < 20000) begin
      step();
      n++;
    end
    if (busy !== want) begin
      chk({15'h0000, busy}, {15'h0000, want});
      end_sim();
    end
  endtask
  task automatic convert(input int c, input logic irqEn);
    int rate = c & 3;
    int osr = (c >> 2) & 7;
    int nelc = (c >> 5) & 3;
    int n = 0, ticks = 0, quants = 0, gap = 0, last = 0, flips = 0;
    logic pol = 1'b0;
    int res = (2 * osr + nelc + 6 > 16) ? 16 : 2 * osr + nelc + 6;
    wr(4'h8, {15'h0000, irqEn});
    wr(4'h1, 16'(32'h000F | (rate << 5)));
    level <= c[7];
    wr(4'h0, 16'((c[8] ? 2 : 1) | (osr << 2) | (nelc << 5)));
    waitBusy(1'b1);
    while (busy === 1'b1 && n < 20000) begin
      step();
      n++;
      if (sampleTick === 1'b1) begin
        ticks++;
        gap = n - last;
        last = n;
      end
      if (quantStrobe === 1'b1) quants++;
      if (chopPolarity !== pol) begin
        flips++;
        pol = chopPolarity;
      end
    end
    waitBusy(1'b0);
    chk(16'(ticks),
      16'((1 << nelc) * ((8 << osr) + 1) + 1));
    chk(16'(flips), 16'(1 << nelc));
    chk(16'(quants), 16'h0001);
    chk(16'(gap), 16'(divTab[rate]));
    step();
    chk({15'h0000, irq}, {15'h0000, irqEn});
    rd(4'h6);
    chk(v, expResult(osr, nelc, c[7]));
    rd(4'h5);
    chk(v & 16'h01F1, 16'(res << 4));
    rd(4'h7);
    chk(v, 16'h0001);
    wr(4'h9, 16'h0003);
    step();
    chk({15'h0000, irq}, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    step();
    chk({15'h0000, busy}, 16'h0000);
    rd(4'h6);
    chk(v, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF);
    chk(v, 16'h0000);
    rd(4'h9);
    chk(v, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = nextRand();
      wr(4'h1, r[15:0] & 16'h007F);
      wr(4'h2, r[15:0]);
      wr(4'h3, r[31:16]);
      wr(4'h4, r[23:8]);
      step();
      chk(16'({stage1_gain_sel, stage3Enable, stage2Enable, stage1Enable,
        adcEnable}), 16'(r[4:0]));
      chk(16'({stage2_offset_sel, stage2_gain_sel}), 16'(r[5:0]));
      chk(16'({stage3_offset_sel, stage3_gain_sel}),
        16'({r[14:8], r[22:16]}));
      rd(4'h2);
      chk(v, r[15:0] & 16'h003F);
      wr(4'h0, {9'h000, r[4:0], 2'h0});
      rd(4'h5);
      chk(v & 16'h01F0, 16'((2 * r[2:0] + r[4:3] + 6 > 16 ? 16
        : 2 * r[2:0] + r[4:3] + 6) << 4));
    end
    foreach (cases[i]) convert(cases[i], i[0]);
    wr(4'h8, 16'h0002);
    wr(4'h1, 16'h000F);
    wr(4'h0, 16'h0009);
    waitBusy(1'b1);
    wr(4'h0, 16'h0001);
    step();
    chk({15'h0000, irq}, 16'h0001);
    rd(4'h7);
    chk(v, 16'h0002);
    wr(4'h9, 16'h0002);
    wr(4'h1, 16'h0000);
    step();
    step();
    chk({15'h0000, busy}, 16'h0000);
    rd(4'h7);
    chk(v, 16'h0000);
    end_sim();
  end
endmodule
